// file: hw/cqp_counter.sv
// One 16-bit counter channel: capture, quadrature decoding and PWM
`timescale 1ns/1ps
module cqp_counter
	import cqp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [2:0] trig_in,
	output cqp_evt_s evt_out,
	output logic pwm_line
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [15:0] cc;
	logic [15:0] cc_buff;
	logic [15:0] period;
	logic [15:0] period_buff;
	logic [11:0] trig_sel;
	logic [11:0] edge_sel;
	logic [5:0] out_act;
	logic run_switch;
	logic [15:0] count;
	logic direction_flag;
	logic running;
	logic sw_pend;
	logic [5:0] cmd_pend;

	logic [2:0] mode;
	logic [1:0] updn;
	logic [1:0] quad_sel;
	logic [7:0] prescale;
	assign mode = ctrl[CTRL_MODE_LSB +: 3];
	assign updn = ctrl[CTRL_UPDN_LSB +: 2];
	assign quad_sel = ctrl[CTRL_QUAD_LSB +: 2];
	assign prescale = ctrl[CTRL_PSC_LSB +: 8];

	function automatic logic edge_hit(input logic [3:0] cur, input logic [3:0] old,
		input logic [11:0] sel, input logic [11:0] edg, input int slot);
		logic [1:0] s;
		logic [1:0] e;
		logic c;
		logic o;
		s = sel[slot*EV_W +: EV_W];
		e = edg[slot*EV_W +: EV_W];
		c = cur[s];
		o = old[s];
		case (e)
			EDGE_RISE: edge_hit = c & ~o;
			EDGE_FALL: edge_hit = ~c & o;
			EDGE_BOTH: edge_hit = c ^ o;
			default: edge_hit = c;
		endcase
	endfunction : edge_hit

	function automatic logic apply_act(input logic line, input logic [1:0] act);
		case (act)
			ACT_SET: apply_act = 1'b1;
			ACT_CLR: apply_act = 1'b0;
			ACT_INV: apply_act = ~line;
			default: apply_act = line;
		endcase
	endfunction : apply_act

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ctrl <= CTRL_RST;
			trig_sel <= TRIG_SEL_RST;
			edge_sel <= EDGE_SEL_RST;
			out_act <= OUT_ACT_RST;
			run_switch <= 1'b0;
		end else if (wr) begin
			case (addr)
				OFS_CTRL: ctrl <= wdata;
				OFS_TRIG_SEL: trig_sel <= wdata[11:0];
				OFS_EDGE_SEL: edge_sel <= wdata[11:0];
				OFS_OUT_ACT: out_act <= wdata[5:0];
				OFS_ENABLE: run_switch <= wdata[ENABLE_BIT];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Tick and trigger sampling
	// ----------------------------------------
	logic [7:0] psc_cnt;
	logic tick;
	logic step_en;
	logic [3:0] trig_cur;
	logic [3:0] trig_old;
	assign tick = run_switch && (psc_cnt == prescale);

	always_ff @(posedge ref_clk) begin
		if (!rst_b || !run_switch || tick) begin
			psc_cnt <= ZERO8;
		end else begin
			psc_cnt <= psc_cnt + ONE8;
		end
	end

	// Sample triggers per tick
	// Slot 0 is a constant high so a count can run without any pin
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			trig_cur <= 4'h1;
			trig_old <= 4'h1;
			step_en <= 1'b0;
		end else begin
			step_en <= tick;
			if (tick) begin
				trig_cur <= {trig_in, 1'b1};
				trig_old <= trig_cur;
			end
		end
	end

	// Parity of edges per tick
	// Only the sampled level is compared, so an even number of edges leaves no trace
	logic cap_ev;
	logic cnt_ev;
	logic rld_ev;
	logic start_ev;
	logic stop_ev;
	logic swt_ev;
	always_comb begin
		cap_ev = (edge_sel[EV_CAP*EV_W +: EV_W] != EDGE_PASS
			&& edge_hit(trig_cur, trig_old, trig_sel, edge_sel, EV_CAP)) | cmd_pend[EV_CAP];
		cnt_ev = edge_hit(trig_cur, trig_old, trig_sel, edge_sel, EV_CNT);
		rld_ev = edge_hit(trig_cur, trig_old, trig_sel, edge_sel, EV_RLD) | cmd_pend[EV_RLD];
		start_ev = edge_hit(trig_cur, trig_old, trig_sel, edge_sel, EV_START)
			| cmd_pend[EV_START];
		stop_ev = edge_hit(trig_cur, trig_old, trig_sel, edge_sel, EV_STOP) | cmd_pend[EV_STOP];
		swt_ev = (edge_sel[EV_SWITCH*EV_W +: EV_W] != EDGE_PASS
			&& edge_hit(trig_cur, trig_old, trig_sel, edge_sel, EV_SWITCH))
			| cmd_pend[EV_SWITCH];
	end

	// Software commands wait for the next step
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cmd_pend <= 6'h00;
		end else begin
			cmd_pend <= (cmd_pend & {6{~step_en}}) | ((wr && addr == OFS_CMD) ? wdata[5:0] : 6'h00);
		end
	end

	// Phase inputs from count and start slots
	logic ph_a;
	logic ph_a_old;
	logic ph_b;
	logic ph_b_old;
	assign ph_a = trig_cur[trig_sel[EV_CNT*EV_W +: EV_W]];
	assign ph_a_old = trig_old[trig_sel[EV_CNT*EV_W +: EV_W]];
	assign ph_b = trig_cur[trig_sel[EV_START*EV_W +: EV_W]];
	assign ph_b_old = trig_old[trig_sel[EV_START*EV_W +: EV_W]];

	// ----------------------------------------
	// Counting engine
	// ----------------------------------------
	logic [15:0] next_count;
	logic next_dir;
	logic next_running;
	logic [15:0] cap_val;
	logic cap_fire;
	logic q_inc;
	logic q_dec;
	logic [15:0] q_val;
	cqp_evt_s ev;

	always_comb begin
		next_count = count;
		next_dir = direction_flag;
		next_running = running;
		cap_val = count;
		cap_fire = 1'b0;
		q_inc = 1'b0;
		q_dec = 1'b0;
		q_val = count;
		ev = '0;
		if (!run_switch) begin
			next_running = 1'b0;
		end else if (mode == MODE_QUAD) begin
			next_running = 1'b1;
			if (step_en) begin
				// Single edge: A rising, B picks way
				// Double and quad add more edges
				if (ph_a && !ph_a_old) begin
					q_inc = !ph_b;
					q_dec = ph_b;
				end else if (!ph_a && ph_a_old && quad_sel != QUAD_SINGLE) begin
					q_inc = ph_b;
					q_dec = !ph_b;
				end else if ((ph_b ^ ph_b_old) && quad_sel != QUAD_SINGLE
					&& quad_sel != QUAD_DOUBLE) begin
					q_inc = (ph_b == ph_a);
					q_dec = (ph_b != ph_a);
				end
				q_val = q_inc ? count + ONE16 : count - ONE16;
				if (rld_ev) begin
					ev.tc = 1'b1;
					cap_fire = 1'b1;
					next_count = (updn == UPDN_UP) ? ZERO16 : period;
				end else if (q_inc || q_dec) begin
					next_dir = q_dec;
					if (q_val == ZERO16 || q_val == MAX16) begin
						ev.cc = 1'b1;
						cap_fire = 1'b1;
						cap_val = q_val;
						next_count = period;
					end else begin
						next_count = q_val;
					end
				end
			end
		end else if (step_en) begin
			if (start_ev || rld_ev) begin
				next_running = 1'b1;
			end
			if (rld_ev) begin
				next_count = (updn == UPDN_DOWN) ? period : ZERO16;
				next_dir = (updn == UPDN_DOWN);
			end else if (running && cnt_ev) begin
				case (updn)
					UPDN_UP: begin
						next_dir = 1'b0;
						if (count >= period) begin
							next_count = ZERO16;
							ev.ov = 1'b1;
							ev.tc = 1'b1;
						end else begin
							next_count = count + ONE16;
						end
					end
					UPDN_DOWN: begin
						next_dir = 1'b1;
						if (count == ZERO16) begin
							next_count = period;
							ev.un = 1'b1;
							ev.tc = 1'b1;
						end else begin
							next_count = count - ONE16;
						end
					end
					default: begin
						// Up and down doubles the period
						if (!direction_flag && count >= period) begin
							next_dir = 1'b1;
							next_count = count - ONE16;
							ev.ov = 1'b1;
							ev.tc = (updn == UPDN_BOTH1);
						end else if (direction_flag && count == ZERO16) begin
							next_dir = 1'b0;
							next_count = count + ONE16;
							ev.un = 1'b1;
							ev.tc = 1'b1;
						end else begin
							next_count = direction_flag ? count - ONE16 : count + ONE16;
						end
					end
				endcase
				if (mode == MODE_PWM && next_count == cc) begin
					ev.cc = 1'b1;
				end
			end
			if (mode == MODE_CAPTURE && running && cap_ev) begin
				cap_fire = 1'b1;
				ev.cc = 1'b1;
			end
			if (stop_ev) begin
				next_running = 1'b0;
			end
			if (ctrl[CTRL_ONESHOT_BIT] && ev.tc) begin
				next_running = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			count <= ZERO16;
			direction_flag <= 1'b0;
			running <= 1'b0;
		end else begin
			count <= (wr && addr == OFS_COUNT) ? wdata[15:0] : next_count;
			direction_flag <= next_dir;
			running <= next_running;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			evt_out <= '0;
		end else begin
			evt_out <= ev;
		end
	end

	// ----------------------------------------
	// Capture, compare and period buffers
	// ----------------------------------------
	logic swap_now;
	assign swap_now = (mode == MODE_PWM) && ev.tc && sw_pend;

	// Switch held until terminal count
	// Set wins over the clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sw_pend <= 1'b0;
		end else if (mode == MODE_PWM && step_en && swt_ev) begin
			sw_pend <= 1'b1;
		end else if (swap_now) begin
			sw_pend <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cc <= ZERO16;
			cc_buff <= ZERO16;
		end else if (cap_fire) begin
			cc <= cap_val;
			cc_buff <= cc;
		end else if (swap_now && ctrl[CTRL_CSWAP_BIT]) begin
			cc <= cc_buff;
			cc_buff <= cc;
		end else if (wr && addr == OFS_CC) begin
			cc <= wdata[15:0];
		end else if (wr && addr == OFS_CC_BUFF) begin
			cc_buff <= wdata[15:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			period <= PERIOD_RST;
			period_buff <= PERIOD_RST;
		end else if (swap_now && ctrl[CTRL_PSWAP_BIT]) begin
			period <= period_buff;
			period_buff <= period;
		end else if (wr && addr == OFS_PERIOD) begin
			period <= wdata[15:0];
		end else if (wr && addr == OFS_PERIOD_BUFF) begin
			period_buff <= wdata[15:0];
		end
	end

	// ----------------------------------------
	// PWM output line
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pwm_line <= 1'b0;
		end else if (mode == MODE_PWM) begin
			if (updn == UPDN_BOTH0 || updn == UPDN_BOTH1) begin
				if (ev.tc) begin
					pwm_line <= 1'b0;
				end else if (ev.cc) begin
					pwm_line <= ~pwm_line;
				end
			end else begin
				pwm_line <= apply_act(apply_act(apply_act(pwm_line,
					ev.ov ? out_act[ACT_OV_LSB +: 2] : EDGE_PASS),
					ev.un ? out_act[ACT_UN_LSB +: 2] : EDGE_PASS),
					ev.cc ? out_act[ACT_CC_LSB +: 2] : EDGE_PASS);
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
				OFS_CTRL: rdata <= ctrl;
				OFS_CC: rdata <= {16'h0000, cc};
				OFS_CC_BUFF: rdata <= {16'h0000, cc_buff};
				OFS_PERIOD: rdata <= {16'h0000, period};
				OFS_PERIOD_BUFF: rdata <= {16'h0000, period_buff};
				OFS_TRIG_SEL: rdata <= {20'h0_0000, trig_sel};
				OFS_EDGE_SEL: rdata <= {20'h0_0000, edge_sel};
				OFS_OUT_ACT: rdata <= {26'h000_0000, out_act};
				OFS_STATE: rdata <= {29'h0000_0000, sw_pend, running, direction_flag};
				OFS_COUNT: rdata <= {16'h0000, count};
				OFS_ENABLE: rdata <= {31'h0000_0000, run_switch};
				default: rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_capture_copy: assert property (cap_fire |=> cc == $past(cap_val) && cc_buff == $past(cc))
		else $error("capture did not copy and shift");
	a_capture_pulse: assert property (cap_fire && mode == MODE_CAPTURE |=> evt_out.cc)
		else $error("capture without match pulse");
	a_capture_mode: assert property (cap_fire |-> mode == MODE_CAPTURE || mode == MODE_QUAD)
		else $error("capture outside capture modes");
	a_capture_source: assert property (cap_fire && mode == MODE_CAPTURE |-> step_en && cap_ev)
		else $error("capture without a source");
	a_oneshot_halt: assert property (mode != MODE_QUAD && ctrl[CTRL_ONESHOT_BIT] && ev.tc
		|=> !running)
		else $error("one-shot kept running");
	a_index_reinit: assert property (mode == MODE_QUAD && step_en && rld_ev && run_switch
		&& !wr |=> evt_out.tc && count == (updn == UPDN_UP ? ZERO16 : $past(period)))
		else $error("index did not reinitialise");
	a_quad_extreme: assert property (mode == MODE_QUAD && ev.cc && !wr
		|=> count == $past(period) && (cc == ZERO16 || cc == MAX16))
		else $error("extreme not reloaded");
	a_dir_flag: assert property (q_inc && !rld_ev |=> !direction_flag)
		else $error("direction flag wrong after increment");
	a_switch_hold: assert property (sw_pend && !swap_now |=> sw_pend)
		else $error("pending switch lost");
	a_center_clear: assert property (mode == MODE_PWM && updn[1] && ev.tc ##1 mode == MODE_PWM
		|-> !pwm_line)
		else $error("center line not cleared");

endmodule : cqp_counter

// file: hw/cqp_pkg.sv
// Constants, field layout and carrier types of the capture/quadrature/PWM counter channel
package cqp_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CC = 8'h04;
	localparam logic [7:0] OFS_CC_BUFF = 8'h08;
	localparam logic [7:0] OFS_PERIOD = 8'h0C;
	localparam logic [7:0] OFS_PERIOD_BUFF = 8'h10;
	localparam logic [7:0] OFS_TRIG_SEL = 8'h14;
	localparam logic [7:0] OFS_EDGE_SEL = 8'h18;
	localparam logic [7:0] OFS_OUT_ACT = 8'h1C;
	localparam logic [7:0] OFS_CMD = 8'h20;
	localparam logic [7:0] OFS_STATE = 8'h24;
	localparam logic [7:0] OFS_COUNT = 8'h28;
	localparam logic [7:0] OFS_ENABLE = 8'h2C;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int CTRL_CSWAP_BIT = 0;
	localparam int CTRL_PSWAP_BIT = 1;
	localparam int CTRL_PSC_LSB = 8;
	localparam int CTRL_UPDN_LSB = 16;
	localparam int CTRL_ONESHOT_BIT = 18;
	localparam int CTRL_QUAD_LSB = 20;
	localparam int CTRL_MODE_LSB = 24;
	localparam int STATE_DIR_BIT = 0;
	localparam int STATE_RUN_BIT = 1;
	localparam int STATE_SWP_BIT = 2;
	localparam int ENABLE_BIT = 0;

	localparam logic [2:0] MODE_CAPTURE = 3'h2;
	localparam logic [2:0] MODE_QUAD = 3'h3;
	localparam logic [2:0] MODE_PWM = 3'h4;
	localparam logic [1:0] UPDN_UP = 2'h0;
	localparam logic [1:0] UPDN_DOWN = 2'h1;
	localparam logic [1:0] UPDN_BOTH0 = 2'h2;
	localparam logic [1:0] UPDN_BOTH1 = 2'h3;
	localparam logic [1:0] QUAD_SINGLE = 2'h0;
	localparam logic [1:0] QUAD_DOUBLE = 2'h1;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam logic [1:0] EDGE_PASS = 2'h3;
	localparam logic [1:0] ACT_SET = 2'h0;
	localparam logic [1:0] ACT_CLR = 2'h1;
	localparam logic [1:0] ACT_INV = 2'h2;

	// ----------------------------------------
	// Event slots: trigger fields and command bits; output action fields
	// ----------------------------------------
	localparam int EV_W = 2;
	localparam int EV_CAP = 0;
	localparam int EV_CNT = 1;
	localparam int EV_RLD = 2;
	localparam int EV_START = 3;
	localparam int EV_STOP = 4;
	localparam int EV_SWITCH = 5;
	localparam int ACT_CC_LSB = 0;
	localparam int ACT_OV_LSB = 2;
	localparam int ACT_UN_LSB = 4;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [11:0] TRIG_SEL_RST = 12'h000;
	localparam logic [11:0] EDGE_SEL_RST = 12'h00C;
	localparam logic [5:0] OUT_ACT_RST = 6'h3F;
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] MAX16 = 16'hFFFF;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] ONE8 = 8'h01;

	typedef struct packed {
		logic cc;
		logic tc;
		logic ov;
		logic un;
	} cqp_evt_s;

endpackage : cqp_pkg

// file: verification/cqp_counter_bench.sv
// Self-checking bench for the capture/quadrature/PWM counter channel
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module cqp_counter_bench
	import cqp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [2:0] trig_in;
	cqp_evt_s evt_out;
	logic pwm_line;
	logic step_req = 1'b0;
	logic step_rev = 1'b0;
	logic idx_lvl = 1'b0;
	int err_count = 0;
	int n_tests = 0;
	int n_cc = 0;
	int n_tc = 0;
	int n_ov = 0;
	int ov0;
	int cc0;
	int tc0;
	int sp;
	int hi;
	logic [31:0] d;

	// ----------------------------------------
	// Clock, instances, event counters
	// ----------------------------------------
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	cqp_counter i_cqp_counter (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.trig_in(trig_in),
		.evt_out(evt_out),
		.pwm_line(pwm_line)
	);

	cqp_encoder_model i_cqp_encoder_model (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.step_req(step_req),
		.step_rev(step_rev),
		.idx_lvl(idx_lvl),
		.trig_in(trig_in)
	);

	// Pulses last one cycle, so sampling the level every clock counts each once
	always @(posedge ref_clk) begin
		if (rst_b === 1'b1) begin
			if (evt_out.cc === 1'b1) n_cc++;
			if (evt_out.tc === 1'b1) n_tc++;
			if (evt_out.ov === 1'b1) n_ov++;
		end
	end

	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rreg

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rreg(a, v);
		`CHK(v, e)
	endtask : rchk

	// Spaced well apart so each phase moves once per tick
	task automatic steps(input int n, input logic rev);
		repeat (n) begin
			@(posedge ref_clk);
			step_req <= 1'b1;
			step_rev <= rev;
			@(posedge ref_clk);
			step_req <= 1'b0;
			idle(2);
		end
		idle(4);
	endtask : steps

	task automatic qcfg(input logic [1:0] qm, input logic [15:0] c);
		wreg(OFS_ENABLE, 32'h0000_0000);
		wreg(OFS_CTRL, {5'h00, MODE_QUAD, 2'h0, qm, 2'h0, UPDN_DOWN, 16'h0000});
		wreg(OFS_PERIOD, 32'h0000_8000);
		wreg(OFS_TRIG_SEL, 32'h0000_03B4);
		wreg(OFS_COUNT, {16'h0000, c});
		wreg(OFS_ENABLE, 32'h0000_0001);
	endtask : qcfg

	task automatic wait_tc;
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (evt_out.tc !== 1'b1 && k < 300);
		if (k >= 300) begin
			err_count++;
			end_sim();
		end
	endtask : wait_tc

	// Window of exactly one period, so phase of entry does not matter
	task automatic measure(output int s, output int h);
		wait_tc();
		s = 0;
		h = 0;
		do begin
			@(posedge ref_clk);
			#1;
			s++;
			if (pwm_line === 1'b1) h++;
		end while (evt_out.tc !== 1'b1 && s < 300);
		if (s >= 300) begin
			err_count++;
			end_sim();
		end
	endtask : measure

	task automatic end_sim;
		$display("comparisons=%0d mismatches=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		idle(6);
		rst_b <= 1'b1;
		rchk(OFS_PERIOD, 32'h0000_FFFF);
		rchk(OFS_EDGE_SEL, 32'h0000_000C);
		rchk(OFS_OUT_ACT, 32'h0000_003F);
		rchk(8'h30, 32'h0000_0000);
		$display("test reset done");

		for (int m = 0; m < 3; m++) begin
			qcfg(m[1:0], 16'h8000);
			steps(4, 1'b0);
			rchk(OFS_COUNT, 32'h0000_8000 + (32'h0000_0001 << m));
			rreg(OFS_STATE, d);
			`CHK(d[STATE_DIR_BIT], 1'b0)
			steps(4, 1'b1);
			rchk(OFS_COUNT, 32'h0000_8000);
			rreg(OFS_STATE, d);
			`CHK(d[STATE_DIR_BIT], 1'b1)
		end
		$display("test quad rate done");

		qcfg(QUAD_SINGLE, 16'h1234);
		tc0 = n_tc;
		@(posedge ref_clk);
		idx_lvl <= 1'b1;
		idle(6);
		`CHK(n_tc - tc0, 1)
		rchk(OFS_CC, 32'h0000_1234);
		rchk(OFS_COUNT, 32'h0000_8000);
		@(posedge ref_clk);
		idx_lvl <= 1'b0;
		wreg(OFS_COUNT, 32'h0000_FFFE);
		cc0 = n_cc;
		steps(4, 1'b0);
		`CHK(n_cc - cc0, 1)
		rchk(OFS_CC, 32'h0000_FFFF);
		rchk(OFS_CC_BUFF, 32'h0000_1234);
		rchk(OFS_COUNT, 32'h0000_8000);
		wreg(OFS_COUNT, 32'h0000_0001);
		steps(4, 1'b1);
		`CHK(n_cc - cc0, 2)
		rchk(OFS_CC, 32'h0000_0000);
		rchk(OFS_CC_BUFF, 32'h0000_FFFF);
		rchk(OFS_COUNT, 32'h0000_8000);
		$display("test quad events done");

		wreg(OFS_ENABLE, 32'h0000_0000);
		wreg(OFS_CTRL, {5'h00, MODE_CAPTURE, 6'h00, UPDN_UP, 16'h0000});
		wreg(OFS_TRIG_SEL, 32'h0000_0FFD);
		wreg(OFS_COUNT, 32'h0000_1111);
		wreg(OFS_ENABLE, 32'h0000_0001);
		wreg(OFS_CMD, 32'h0000_0008);
		cc0 = n_cc;
		steps(1, 1'b0);
		`CHK(n_cc - cc0, 1)
		rchk(OFS_CC, 32'h0000_1111);
		wreg(OFS_COUNT, 32'h0000_2222);
		wreg(OFS_CMD, 32'h0000_0001);
		idle(4);
		rchk(OFS_CC, 32'h0000_2222);
		rchk(OFS_CC_BUFF, 32'h0000_1111);
		steps(3, 1'b0);
		`CHK(n_cc - cc0, 2)
		rchk(OFS_CC, 32'h0000_2222);
		$display("test capture done");

		wreg(OFS_ENABLE, 32'h0000_0000);
		wreg(OFS_CTRL, {5'h00, MODE_PWM, 6'h00, UPDN_BOTH0, 14'h0000, 2'h3});
		wreg(OFS_PERIOD, 32'h0000_0008);
		wreg(OFS_CC, 32'h0000_0003);
		wreg(OFS_PERIOD_BUFF, 32'h0000_000C);
		wreg(OFS_CC_BUFF, 32'h0000_0005);
		wreg(OFS_TRIG_SEL, 32'h0000_0FF3);
		wreg(OFS_OUT_ACT, 32'h0000_003E);
		wreg(OFS_ENABLE, 32'h0000_0001);
		// Reload too, so a stale count and direction do not carry over
		wreg(OFS_CMD, 32'h0000_000C);
		measure(sp, hi);
		`CHK(sp, 16)
		`CHK(hi, 10)
		wreg(OFS_CMD, 32'h0000_0020);
		// Second window is sure to follow the swap
		measure(sp, hi);
		measure(sp, hi);
		`CHK(sp, 24)
		`CHK(hi, 14)
		rchk(OFS_PERIOD, 32'h0000_000C);
		rchk(OFS_CC, 32'h0000_0005);
		rchk(OFS_PERIOD_BUFF, 32'h0000_0008);
		rreg(OFS_STATE, d);
		`CHK(d[STATE_SWP_BIT], 1'b0)
		$display("test pwm done");

		wreg(OFS_ENABLE, 32'h0000_0000);
		wreg(OFS_CTRL, {5'h00, MODE_PWM, 5'h00, 1'b1, UPDN_UP, 8'h01, 8'h00});
		wreg(OFS_PERIOD, 32'h0000_0004);
		wreg(OFS_CC, 32'h0000_0002);
		wreg(OFS_OUT_ACT, 32'h0000_0031);
		wreg(OFS_ENABLE, 32'h0000_0001);
		tc0 = n_tc;
		ov0 = n_ov;
		// Second pass starts with the line high, so the clear action must show
		for (int r = 0; r < 2; r++) begin
			wreg(OFS_CMD, 32'h0000_000C);
			idle(7);
			#1;
			`CHK(pwm_line, 1'b0)
			wait_tc();
			`CHK(pwm_line, 1'b1)
			idle(20);
			rchk(OFS_COUNT, 32'h0000_0000);
			rchk(OFS_STATE, 32'h0000_0000);
		end
		`CHK(n_tc - tc0, 2)
		`CHK(n_ov - ov0, 2)
		$display("test one-shot done");
		end_sim();
	end
endmodule : cqp_counter_bench

// file: verification/cqp_encoder_model.sv
// Encoder and trigger pin model for the counter channel's trigger inputs
`timescale 1ns/1ps
module cqp_encoder_model
	import cqp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic step_req,
	input wire logic step_rev,
	input wire logic idx_lvl,
	output logic [2:0] trig_in
);
	logic [1:0] pos;

	// ----------------------------------------
	// Phase sequence
	// ----------------------------------------
	// One quarter step per request
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pos <= 2'h0;
		end else if (step_req) begin
			pos <= step_rev ? pos - 2'h1 : pos + 2'h1;
		end
	end

	assign trig_in = {idx_lvl, pos[1], pos[1] ^ pos[0]};
endmodule : cqp_encoder_model
